// File: hdl/tcdp_top.sv
/*
  Tape controller data path: command fetch, read and write flows.
  Assumes a host memory port that answers each request with one ack
  pulse, and a transport that strobes bytes synchronous to core_clk.
*/
// Notes on behaviour
// - Read bytes arrive as eight data lines and parity, captured into FIFO.
// - Parity rechecked on each read byte; mismatch sets sticky error.
// - Any byte at the FIFO output is removed; while count remains, it goes into internal storage.
// - Two assembled bytes form a word written to host memory.
// - Read runs until record delivered and stored, or fatal error.
// - Remaining count tracked against requested length; residual kept.
// - Overlong record stops at zero count, excess dropped, error reported.
// - Read completion updates status, then writes message packet.
// - Command packet fetched one word per host read.
// - Write prefills FIFO before issuing the transport command.
// - Parity generated at FIFO output, driven with write byte.
// - FIFO kept refilled from host, two bytes per transfer, one when a single byte is left.
// - After whole block enters FIFO and drains, last-word signal asserts.
// - Write completion writes message packet and updates status.
// - New command accepted while tape decelerates after a read; a write waits for op_done; writes stream.
// - Transport started by command code then command strobe pulse.
// - Address steps two per word, one per byte, up or down.
`timescale 1ns/1ps
module tcdp_top
  import tcdp_pkg::*;
#(
  parameter int DEPTH = TCDP_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ptr_load,
  input wire logic [TCDP_ADDR_W-1:0] command_pointer_register,
  output logic busy,
  output logic [TCDP_WORD_W-1:0] subsystem_status_register,
  output logic [TCDP_CNT_W-1:0] residual_byte_count,
  output logic mem_req,
  output logic mem_we,
  output logic [TCDP_ADDR_W-1:0] mem_addr,
  output logic [TCDP_WORD_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [TCDP_WORD_W-1:0] mem_rdata,
  output logic [TCDP_CODE_W-1:0] command_code,
  output logic command_strobe,
  input wire logic read_byte_strobe,
  input wire logic [TCDP_BYTE_W-1:0] read_data_lines,
  input wire logic read_parity_line,
  input wire logic record_end,
  input wire logic write_byte_strobe,
  output logic [TCDP_BYTE_W-1:0] write_data_lines,
  output logic write_parity_line,
  output logic last_word_signal,
  input wire logic write_check_error,
  input wire logic op_done,
  input wire logic fatal_error
);
  tcdp_state_e state;
  logic [2:0] pkt_idx;
  logic [TCDP_WORD_W-1:0] cmd_word;
  logic [TCDP_CNT_W-1:0] requested_byte_count;
  logic [TCDP_CNT_W-1:0] host_left;
  logic is_write;
  logic lo_full;
  logic [TCDP_BYTE_W-1:0] lo_byte;
  logic rec_ended;
  logic f_push;
  logic f_pop;
  logic f_clear;
  logic [TCDP_BYTE_W:0] f_in;
  logic [TCDP_BYTE_W:0] f_out;
  logic f_full;
  logic f_empty;
  logic [1:0] f_room;
  logic [TCDP_BYTE_W:0] hi_hold;
  logic hi_pend;
  logic rd_pop;
  logic wr_pop;
  logic [TCDP_ADDR_W-1:0] ptr_hold;
  logic [TCDP_ADDR_W-1:0] data_addr;

  ////////////////////////////////////////////////////////////////////////
  // FIFO carrying byte plus parity; write side stores a spare zero bit
  tcdp_fifo #(.WIDTH(TCDP_BYTE_W + 1), .DEPTH(DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .clear(f_clear),
    .push(f_push),
    .push_data(f_in),
    .pop(f_pop),
    .pop_data(f_out),
    .full(f_full),
    .empty(f_empty)
  );

  assign f_clear = (state == TCDP_IDLE);
  assign busy = (state != TCDP_IDLE);
  // Read pops only while no host write is in flight; a pop then is lost
  assign rd_pop = !is_write && (state == TCDP_XFER) && !f_empty &&
    !mem_req;
  assign wr_pop = is_write && write_byte_strobe && !f_empty;
  assign f_pop = rd_pop || wr_pop;
  // Second byte of a fetched word is staged while the FIFO is full
  assign f_room = f_full ? 2'h0 : 2'h1;
  always_comb begin
    f_push = 1'b0;
    f_in = {1'b0, hi_hold[TCDP_BYTE_W-1:0]};
    if (!is_write) begin
      f_push = read_byte_strobe && busy;
      f_in = {read_parity_line, read_data_lines};
    end else if (hi_pend) begin
      f_push = 1'b1;
    end else if (mem_req && mem_ack && state != TCDP_MSG &&
        state != TCDP_FETCH) begin
      f_push = 1'b1;
      f_in = {1'b0, mem_rdata[TCDP_BYTE_W-1:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= TCDP_IDLE;
      pkt_idx <= 3'h0;
      is_write <= 1'b0;
      cmd_word <= TCDP_ZERO_CNT;
    end else begin
      case (state)
        TCDP_IDLE: begin
          if (ptr_load) begin
            state <= TCDP_FETCH;
            pkt_idx <= 3'h0;
          end
        end
        TCDP_FETCH: begin
          if (mem_ack) begin
            if (pkt_idx == TCDP_PKT_CMD) begin
              cmd_word <= mem_rdata;
              is_write <= mem_rdata[TCDP_CMD_WRITE_BIT];
            end
            if (pkt_idx == TCDP_PKT_LAST) begin
              state <= TCDP_DECIDE;
            end
            pkt_idx <= pkt_idx + 3'h1;
          end
        end
        TCDP_DECIDE: begin
          state <= is_write ? TCDP_PREFILL : TCDP_ISSUE;
        end
        TCDP_PREFILL: begin
          if (f_full || host_left == TCDP_ZERO_CNT) begin
            state <= TCDP_ISSUE;
          end
        end
        TCDP_ISSUE: begin
          state <= TCDP_XFER;
        end
        TCDP_XFER: begin
          if (fatal_error) begin
            state <= TCDP_STATUS;
          end else if (is_write && host_left == TCDP_ZERO_CNT &&
              !hi_pend && !mem_req) begin
            state <= TCDP_DRAIN;
          end else if (!is_write && rec_ended && f_empty && !mem_req &&
              !read_byte_strobe) begin
            state <= lo_full ? TCDP_XFER : TCDP_STATUS;
          end
        end
        TCDP_DRAIN: begin
          if (fatal_error) begin
            state <= TCDP_STATUS;
          end else if (f_empty) begin
            state <= TCDP_WAITDONE;
          end
        end
        TCDP_WAITDONE: begin
          if (op_done || fatal_error) begin
            state <= TCDP_STATUS;
          end
        end
        TCDP_STATUS: begin
          state <= TCDP_MSG;
        end
        TCDP_MSG: begin
          if (mem_ack) begin
            state <= TCDP_IDLE;
          end
        end
        default: begin
          state <= TCDP_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte counts; the read side counts down as bytes leave the FIFO
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      requested_byte_count <= TCDP_ZERO_CNT;
      residual_byte_count <= TCDP_ZERO_CNT;
      host_left <= TCDP_ZERO_CNT;
    end else if (state == TCDP_FETCH && mem_ack &&
        pkt_idx == TCDP_PKT_CNT) begin
      requested_byte_count <= mem_rdata;
      residual_byte_count <= mem_rdata;
      host_left <= mem_rdata;
    end else begin
      if (rd_pop && residual_byte_count != TCDP_ZERO_CNT) begin
        residual_byte_count <= residual_byte_count - TCDP_ONE_CNT;
      end
      if (wr_pop) begin
        residual_byte_count <= residual_byte_count - TCDP_ONE_CNT;
      end
      if (is_write && mem_req && mem_ack && state != TCDP_MSG &&
          state != TCDP_FETCH) begin
        host_left <= (host_left > TCDP_ONE_CNT) ?
          host_left - TCDP_TWO_CNT : TCDP_ZERO_CNT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host memory port: packet fetch, data words and message write-back
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= TCDP_ZERO_CNT;
      lo_full <= 1'b0;
      lo_byte <= '0;
      hi_hold <= '0;
      hi_pend <= 1'b0;
      ptr_hold <= '0;
      data_addr <= '0;
    end else begin
      if (hi_pend && !f_full) begin
        hi_pend <= 1'b0;
      end
      if (state == TCDP_IDLE && ptr_load) begin
        mem_addr <= command_pointer_register;
        ptr_hold <= command_pointer_register;
        mem_req <= 1'b1;
        mem_we <= 1'b0;
      end else if (mem_req && mem_ack) begin
        mem_req <= 1'b0;
        if (state == TCDP_FETCH) begin
          // Packet words follow the pointer; the data pointer waits aside
          mem_addr <= mem_addr + TCDP_WORD_STEP;
          if (pkt_idx == TCDP_PKT_ADLO) begin
            data_addr[TCDP_WORD_W-1:0] <= mem_rdata;
          end else if (pkt_idx == TCDP_PKT_ADHI) begin
            data_addr[TCDP_ADDR_W-1:TCDP_WORD_W] <= mem_rdata[1:0];
          end
          if (pkt_idx != TCDP_PKT_LAST) begin
            mem_req <= 1'b1;
          end
        end else if (state != TCDP_MSG) begin
          // Step by a word, or a byte for an odd tail, either way
          mem_addr <= cmd_word[TCDP_CMD_DOWN_BIT] ?
            mem_addr - (mem_we && lo_full && !is_write ?
              TCDP_BYTE_STEP : TCDP_WORD_STEP) :
            mem_addr + (mem_we && lo_full && !is_write ?
              TCDP_BYTE_STEP : TCDP_WORD_STEP);
          if (is_write && host_left > TCDP_ONE_CNT) begin
            hi_hold <= {1'b0, mem_rdata[TCDP_WORD_W-1:TCDP_BYTE_W]};
            hi_pend <= 1'b1;
          end
        end
      end else if (state == TCDP_DECIDE) begin
        mem_addr <= data_addr;
      end else if (state == TCDP_STATUS) begin
        // Message carries the status as it is updated in this same cycle
        mem_addr <= ptr_hold;
        mem_wdata <= subsystem_status_register;
        mem_wdata[TCDP_ST_DONE] <= 1'b1;
        mem_wdata[TCDP_ST_WRITE] <= is_write;
        mem_req <= 1'b1;
        mem_we <= 1'b1;
      end else if (is_write && !mem_req && !hi_pend &&
          f_room != 2'h0 && host_left != TCDP_ZERO_CNT &&
          (state == TCDP_PREFILL || state == TCDP_XFER)) begin
        mem_req <= !f_full;
        mem_we <= 1'b0;
      end else if (!is_write && state == TCDP_XFER && !mem_req) begin
        if (rd_pop && residual_byte_count != TCDP_ZERO_CNT) begin
          if (lo_full) begin
            mem_wdata <= {f_out[TCDP_BYTE_W-1:0], lo_byte};
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            lo_full <= 1'b0;
          end else begin
            lo_byte <= f_out[TCDP_BYTE_W-1:0];
            lo_full <= 1'b1;
          end
        end else if (lo_full && rec_ended && f_empty &&
            !read_byte_strobe) begin
          mem_wdata <= {{TCDP_BYTE_W{1'b0}}, lo_byte};
          mem_req <= 1'b1;
          mem_we <= 1'b1; // odd tail byte leaves as a word write, high byte zero
        end
      end
      // Tail byte has left, so the word slot is free again
      if (state == TCDP_XFER && mem_req && mem_ack && lo_full) begin
        lo_full <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status and sticky error flags; set wins over the clear at a new start
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      subsystem_status_register <= TCDP_ST_RESET;
      rec_ended <= 1'b0;
    end else begin
      if (state == TCDP_IDLE && ptr_load) begin
        subsystem_status_register <= TCDP_ST_RESET;
        rec_ended <= 1'b0;
      end
      if (record_end && busy) begin
        rec_ended <= 1'b1;
      end
      if (!is_write && read_byte_strobe && busy &&
          ((^read_data_lines) == read_parity_line)) begin
        subsystem_status_register[TCDP_ST_PAR] <= 1'b1;
      end
      if (rd_pop && residual_byte_count == TCDP_ZERO_CNT) begin
        subsystem_status_register[TCDP_ST_OVR] <= 1'b1;
      end
      if (is_write && busy && write_check_error) begin
        subsystem_status_register[TCDP_ST_RAW] <= 1'b1;
      end
      if (state == TCDP_STATUS) begin
        subsystem_status_register[TCDP_ST_DONE] <= 1'b1;
        subsystem_status_register[TCDP_ST_WRITE] <= is_write;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transport side outputs, all registered
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      command_code <= '0;
      command_strobe <= 1'b0;
      last_word_signal <= 1'b0;
      write_data_lines <= '0;
      write_parity_line <= 1'b0;
    end else begin
      command_strobe <= (state == TCDP_ISSUE);
      if (state == TCDP_DECIDE) begin
        command_code <= cmd_word[TCDP_CODE_W-1:0];
      end
      last_word_signal <= (state == TCDP_DRAIN) && f_empty;
      if (wr_pop) begin
        write_data_lines <= f_out[TCDP_BYTE_W-1:0];
        write_parity_line <= ~(^f_out[TCDP_BYTE_W-1:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_issue;
    state == TCDP_ISSUE;
  endsequence
  a_strobe_after_issue: assert property (
    @(posedge core_clk) disable iff (rst) s_issue |=> command_strobe)
    else $error("command strobe missing after issue");
  a_parity_sticky: assert property (
    @(posedge core_clk) disable iff (rst)
    !is_write && read_byte_strobe && busy &&
    ((^read_data_lines) == read_parity_line)
    |=> subsystem_status_register[TCDP_ST_PAR])
    else $error("parity error not flagged");
  a_write_parity: assert property (
    @(posedge core_clk) disable iff (rst) wr_pop |=>
    write_parity_line == ~(^write_data_lines))
    else $error("write parity wrong");
  a_lwd_when_empty: assert property (
    @(posedge core_clk) disable iff (rst)
    last_word_signal |-> $past(f_empty))
    else $error("last word before fifo empty");
  a_no_pull_full: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(mem_req) && is_write && !mem_we |-> !$past(f_full))
    else $error("host pull while fifo full");
  sequence s_count_spent;
    rd_pop && residual_byte_count == TCDP_ZERO_CNT;
  endsequence
  a_overlong_flag: assert property (
    @(posedge core_clk) disable iff (rst) s_count_spent |=>
    subsystem_status_register[TCDP_ST_OVR] &&
    residual_byte_count == TCDP_ZERO_CNT)
    else $error("overlong record not stopped");
endmodule // tcdp_top

// File: include/tcdp_pkg.sv
/*
  Shared constants and types for the tape controller data path.
  Assumes a single 125 MHz core clock and word-wide host memory.
*/
package tcdp_pkg;
  localparam int TCDP_BYTE_W = 8;
  localparam int TCDP_WORD_W = 16;
  localparam int TCDP_ADDR_W = 18;
  localparam int TCDP_CNT_W = 16;
  localparam int TCDP_CODE_W = 4;
  localparam int TCDP_FIFO_DEPTH = 16;
  // Command packet word offsets, in words from the pointer
  localparam logic [2:0] TCDP_PKT_CMD = 3'h0;
  localparam logic [2:0] TCDP_PKT_ADLO = 3'h1;
  localparam logic [2:0] TCDP_PKT_ADHI = 3'h2;
  localparam logic [2:0] TCDP_PKT_CNT = 3'h3;
  localparam logic [2:0] TCDP_PKT_LAST = 3'h3;
  // Command word fields
  localparam int TCDP_CMD_WRITE_BIT = 4;
  localparam int TCDP_CMD_DOWN_BIT = 5;
  // Address steps
  localparam logic [17:0] TCDP_WORD_STEP = 18'h00002;
  localparam logic [17:0] TCDP_BYTE_STEP = 18'h00001;
  // Status word bits
  localparam int TCDP_ST_PAR = 0;
  localparam int TCDP_ST_OVR = 1;
  localparam int TCDP_ST_RAW = 2;
  localparam int TCDP_ST_DONE = 3;
  localparam int TCDP_ST_WRITE = 4;
  localparam logic [15:0] TCDP_ST_RESET = 16'h0000;
  localparam logic [15:0] TCDP_ZERO_CNT = 16'h0000;
  localparam logic [15:0] TCDP_ONE_CNT = 16'h0001;
  localparam logic [15:0] TCDP_TWO_CNT = 16'h0002;

  typedef enum logic [3:0] {
    TCDP_IDLE = 4'h0,
    TCDP_FETCH = 4'h1,
    TCDP_DECIDE = 4'h2,
    TCDP_PREFILL = 4'h3,
    TCDP_ISSUE = 4'h4,
    TCDP_XFER = 4'h5,
    TCDP_DRAIN = 4'h6,
    TCDP_WAITDONE = 4'h7,
    TCDP_STATUS = 4'h8,
    TCDP_MSG = 4'h9
  } tcdp_state_e;
endpackage

// File: hdl/tcdp_fifo.sv
/*
  Byte FIFO between the transport interface and the word path.
  Assumes one clock; push and pop are ignored when full or empty.
*/
`timescale 1ns/1ps
module tcdp_fifo
  import tcdp_pkg::*;
#(
  parameter int WIDTH = TCDP_BYTE_W,
  parameter int DEPTH = TCDP_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] pop_data,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic do_push;
  logic do_pop;

  // Guarded strobes keep pointers honest
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) &&
    (wr_ptr[AW] != rd_ptr[AW]);
  assign empty = wr_ptr == rd_ptr;
  assign pop_data = mem[rd_ptr[AW-1:0]];

  // Storage
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wr_ptr[AW-1:0]] <= push_data;
    end
  end

  // Pointers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // tcdp_fifo

// File: verif/tcdp_xport_model.sv
/*
  Behavioural tape transport formatter for the data path bench.
  Assumes the bench sets the mode fields before each command strobe.
*/
`timescale 1ns/1ps
module tcdp_xport_model
  import tcdp_pkg::*;
(
  input wire logic core_clk,
  input wire logic command_strobe,
  input wire logic [TCDP_BYTE_W-1:0] write_data_lines,
  input wire logic write_parity_line,
  input wire logic last_word_signal,
  output logic read_byte_strobe,
  output logic [TCDP_BYTE_W-1:0] read_data_lines,
  output logic read_parity_line,
  output logic record_end,
  output logic write_byte_strobe,
  output logic write_check_error,
  output logic op_done
);
  logic wr_mode;
  logic wck;
  logic lw_seen;
  logic lw_hit = 1'b0;
  int bad_idx;
  int wr_n;
  logic [TCDP_BYTE_W-1:0] rec_q[$];
  logic [TCDP_BYTE_W:0] got_q[$];

  //////////////////////////////////////////////////////////////////////
  // Quiet lines at time zero
  initial begin
    {read_byte_strobe, record_end, write_byte_strobe} = 3'h0;
    {write_check_error, op_done, wr_mode, wck, lw_seen} = 5'h0;
    {read_parity_line, read_data_lines} = 9'h0;
    bad_idx = -1;
    wr_n = 0;
  end

  // Bytes leave corrected, odd parity unless one is spoilt on purpose
  task automatic send_record();
    foreach (rec_q[i]) begin
      read_byte_strobe <= 1'b1;
      read_data_lines <= rec_q[i];
      read_parity_line <= ~^rec_q[i] ^ (i == bad_idx);
      @(negedge core_clk);
      read_byte_strobe <= 1'b0;
      read_data_lines <= ~rec_q[i]; // Released lines must not hold the byte
      repeat (1 + i % 2) @(negedge core_clk);
    end
    record_end <= 1'b1;
    @(negedge core_clk);
    record_end <= 1'b0;
  endtask

  // Pull each byte, take it two edges later, then close the operation
  task automatic pull_block();
    repeat (8) @(negedge core_clk); // Tape coming up to speed
    repeat (wr_n) begin
      write_byte_strobe <= 1'b1;
      @(negedge core_clk);
      write_byte_strobe <= 1'b0;
      repeat (2) @(negedge core_clk);
      got_q.push_back({write_parity_line, write_data_lines});
    end
    for (int k = 0; k < 40 && lw_hit !== 1'b1; k++)
      @(negedge core_clk);
    lw_seen = lw_hit;
    write_check_error <= wck;
    repeat (3) @(negedge core_clk); // Postamble and verify
    op_done <= 1'b1;
    @(negedge core_clk);
    {op_done, write_check_error} <= 2'h0;
  endtask

  // Last word is a one-cycle pulse, so it is latched for the pull task
  always @(posedge core_clk) begin
    lw_hit <= (command_strobe === 1'b1) ? 1'b0 :
      lw_hit | (last_word_signal === 1'b1);
  end

  // Each command strobe starts one operation
  always @(posedge core_clk) begin
    if (command_strobe === 1'b1) begin
      @(negedge core_clk);
      if (wr_mode) begin
        pull_block();
      end else begin
        repeat (3) @(negedge core_clk);
        send_record();
      end
    end
  end
endmodule // tcdp_xport_model

// File: verif/tb_top.sv
/*
  Self-checking bench for the tape controller data path.
  Assumes the transport model and the design files are compiled first.
*/
`timescale 1ns/1ps
module tb_top
  import tcdp_pkg::*;
;
  logic core_clk, rst, ptr_load, busy, mem_req, mem_we, mem_ack;
  logic [17:0] command_pointer_register, mem_addr;
  logic [15:0] subsystem_status_register, residual_byte_count;
  logic [15:0] mem_wdata, mem_rdata;
  logic [3:0] command_code;
  logic command_strobe, read_byte_strobe, read_parity_line, record_end;
  logic [7:0] read_data_lines, write_data_lines;
  logic write_byte_strobe, write_parity_line, last_word_signal;
  logic write_check_error, op_done, fatal_error;
  logic [31:0] seed = 32'h9a97;
  int n_fail = 0;
  int checked = 0;
  int n_rd;
  int dly = 0;
  logic [15:0] mem [logic [17:0]];
  logic [34:0] exp_q[$];
  logic [34:0] e;
  logic [8:0] wexp_q[$];

  tcdp_top i_tcdp_top (.core_clk(core_clk), .rst(rst),
    .ptr_load(ptr_load),
    .command_pointer_register(command_pointer_register),
    .busy(busy), .subsystem_status_register(subsystem_status_register),
    .residual_byte_count(residual_byte_count), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .command_code(command_code), .command_strobe(command_strobe),
    .read_byte_strobe(read_byte_strobe),
    .read_data_lines(read_data_lines),
    .read_parity_line(read_parity_line), .record_end(record_end),
    .write_byte_strobe(write_byte_strobe),
    .write_data_lines(write_data_lines),
    .write_parity_line(write_parity_line),
    .last_word_signal(last_word_signal),
    .write_check_error(write_check_error), .op_done(op_done),
    .fatal_error(fatal_error));

  tcdp_xport_model i_tcdp_xport_model (.core_clk(core_clk),
    .command_strobe(command_strobe),
    .write_data_lines(write_data_lines),
    .write_parity_line(write_parity_line),
    .last_word_signal(last_word_signal),
    .read_byte_strobe(read_byte_strobe),
    .read_data_lines(read_data_lines),
    .read_parity_line(read_parity_line), .record_end(record_end),
    .write_byte_strobe(write_byte_strobe),
    .write_check_error(write_check_error), .op_done(op_done));

  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Host memory acks after 0 to 2 idle cycles; idle data keeps changing
  always @(negedge core_clk) begin
    if (mem_req === 1'b1 && mem_ack !== 1'b1 && dly == 0) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : '1;
      check({mem_we, mem_addr, mem_we ? mem_wdata : 16'h0},
            {e[34:16], e[34] ? e[15:0] : 16'h0});
      mem_ack <= 1'b1;
      mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 16'h0bad;
      n_rd += int'(!mem_we);
      dly = int'(rnd() % 3);
    end else begin
      if (mem_req === 1'b1 && mem_ack !== 1'b1) dly--;
      mem_ack <= 1'b0;
      mem_rdata <= 16'(rnd());
    end
  end

  // One command from pointer load to message, checked against the model
  task automatic run_op(input logic [17:0] ptr, input logic wr,
      input logic dn, input logic [3:0] code, input logic [17:0] base,
      input int cnt, input int nrec, input int bad, input logic wck);
    logic [15:0] st;
    logic [15:0] w;
    logic [17:0] a;
    int nx;
    int k;
    mem[ptr] = {10'h0, dn, wr, code};
    mem[ptr + 18'h2] = base[15:0];
    mem[ptr + 18'h4] = {14'h0, base[17:16]};
    mem[ptr + 18'h6] = cnt[15:0];
    for (k = 0; k < 8; k += 2) exp_q.push_back({1'b0, ptr + 18'(k), 16'h0});
    i_tcdp_xport_model.rec_q = {};
    i_tcdp_xport_model.got_q = {};
    wexp_q = {};
    for (k = 0; k < nrec && !wr; k++)
      i_tcdp_xport_model.rec_q.push_back(8'(rnd()));
    nx = nrec < cnt ? nrec : cnt;
    a = base;
    for (k = 0; k < nx; k += 2) begin
      w = 16'(rnd());
      if (wr) begin
        mem[a] = w;
        exp_q.push_back({1'b0, a, 16'h0});
        wexp_q.push_back({~^w[7:0], w[7:0]});
        wexp_q.push_back({~^w[15:8], w[15:8]});
      end else begin
        w[7:0] = i_tcdp_xport_model.rec_q[k];
        w[15:8] = k + 1 < nx ? i_tcdp_xport_model.rec_q[k + 1] : 8'h0;
        exp_q.push_back({1'b1, a, w});
      end
      a = dn ? a - 18'h2 : a + 18'h2;
    end
    st = {11'h0, wr, 1'b1, wr & wck, nrec > cnt, bad >= 0 && bad < nx};
    exp_q.push_back({1'b1, ptr, st});
    i_tcdp_xport_model.wr_mode = wr;
    i_tcdp_xport_model.wr_n = cnt;
    i_tcdp_xport_model.bad_idx = bad;
    i_tcdp_xport_model.wck = wck;
    @(negedge core_clk);
    n_rd = 0;
    command_pointer_register <= ptr;
    ptr_load <= 1'b1;
    @(negedge core_clk);
    ptr_load <= 1'b0;
    for (k = 0; k < 2000 && command_strobe !== 1'b1; k++)
      @(negedge core_clk);
    check({command_code, command_strobe}, {code, 1'b1});
    if (wr) check(n_rd > 4, 1'b1);
    // A load while busy must leave the running command untouched
    command_pointer_register <= ptr + 18'h40;
    ptr_load <= 1'b1;
    @(negedge core_clk);
    ptr_load <= 1'b0;
    for (k = 0; k < 4000 && busy !== 1'b0; k++) @(negedge core_clk);
    check(exp_q.size(), 0);
    check({subsystem_status_register, residual_byte_count},
          {st, 16'(cnt - nx)});
    if (wr) begin
      check(i_tcdp_xport_model.lw_seen, 1'b1);
      check(i_tcdp_xport_model.got_q.size(), cnt);
      foreach (wexp_q[i])
        check(i_tcdp_xport_model.got_q[i], wexp_q[i]);
    end
  endtask

  //////////////////////////////////////////////////////////////////////
  // Clock at 125 MHz
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Cuts a hang short well beyond the expected run length
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end

  // Main sequence; the second write runs last, after two reads
  initial begin
    rst = 1'b1;
    ptr_load = 1'b0;
    command_pointer_register = 18'h0;
    mem_ack = 1'b0;
    mem_rdata = 16'h0;
    fatal_error = 1'b0;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    run_op(18'h00100, 1'b0, 1'b1, 4'h1, 18'h21000, 6, 6, -1, 1'b0);
    run_op(18'h00200, 1'b1, 1'b0, 4'h3, 18'h03000, 6, 6, -1, 1'b1);
    run_op(18'h00300, 1'b0, 1'b0, 4'h1, 18'h04000, 8, 5, 2, 1'b0);
    run_op(18'h00400, 1'b0, 1'b0, 4'h9, 18'h05000, 4, 7, -1, 1'b0);
    run_op(18'h00500, 1'b1, 1'b0, 4'h3, 18'h06000, 4, 4, -1, 1'b0);
    tally_and_finish();
  end
endmodule // tb_top
